// file: hw/gss_map.svh
// constants for the guard status signal logic
`ifndef GSS_MAP_SVH
`define GSS_MAP_SVH
`define GSS_SYNC_STAGES 2
`define GSS_FRAME_BITS 16
`define GSS_BIT_PERIOD 200
`define GSS_ACYC_EVERY 4
`define GSS_ACYC_WORD 16'h0A5C
`endif

// file: hw/gss_pkg.sv
// types for the guard status signal logic
package gss_pkg;
  typedef enum logic [1:0] {GSS_TX_IDLE, GSS_TX_SHIFT} gss_tx_t;
endpackage

// file: hw/gss_core.sv
// output and status logic of a coded guard interlock switch
`timescale 1ns/1ps
`default_nettype none
`include "gss_map.svh"

module gss_core #(
  parameter int FRAME_BITS = `GSS_FRAME_BITS,
  parameter int BIT_PERIOD = `GSS_BIT_PERIOD
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // sensing pins
  input wire logic i_code_valid,
  input wire logic i_head_entered,
  input wire logic i_full_insert,
  input wire logic i_solenoid_v,
  input wire logic i_manual_release,
  input wire logic i_pin_extended,
  input wire logic i_pin_jammed,
  input wire logic i_tensile_load,
  input wire logic i_chain_enable,
  input wire logic i_internal_fault,
  // configuration
  input wire logic i_mode_active,
  input wire logic i_chain_used,
  input wire logic i_gateway_present,
  // safety outputs
  output logic o_safe_out_a,
  output logic o_safe_out_b,
  // status signals
  output logic o_lock_status,
  output logic o_door_pos_first,
  output logic o_door_pos_second,
  output logic o_diag_flag,
  output logic o_diag_indicator,
  output logic o_manual_release_flag,
  output logic o_output_on_flag,
  output logic o_jammed_locker_flag,
  output logic o_lock_drive,
  // monitoring output with communication
  output logic o_comm_out
);

  // refuse sizes that the shift register and the divider cannot hold
  if (FRAME_BITS < 2 || FRAME_BITS > 16 || BIT_PERIOD < 2 || BIT_PERIOD > 65535)
  begin : g_bad_param
    $error("gss_core: unsupported parameter");
  end

  localparam int NIN = 11;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync_a;
  logic [NIN-1:0] sync_b;
  assign raw_in = {i_code_valid, i_head_entered, i_full_insert, i_solenoid_v, i_manual_release,
                   i_pin_extended, i_pin_jammed, i_tensile_load, i_chain_enable,
                   i_internal_fault, i_gateway_present};

  // two flip-flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_sync
      always_ff @(posedge i_mclk)
      begin
        if (i_sys_rst)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic s_code, s_head, s_full, s_sol, s_man, s_pin, s_jam, s_load, s_chain, s_fault, s_gw;
  assign {s_code, s_head, s_full, s_sol, s_man, s_pin, s_jam, s_load, s_chain, s_fault, s_gw} = sync_b;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic safe;
    logic lock;
    logic door1;
    logic door2;
    logic diag;
    logic fault_latch;
    logic man_flag;
    logic jam;
    logic drive;
    logic comm;
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    logic [15:0] divcnt;
    logic [2:0] framecnt;
    gss_pkg::gss_tx_t tx;
  } gss_state_t;

  gss_state_t st;
  gss_state_t next_st;

  // ****************************************
  // combinational next state
  // ****************************************
  logic guard_open;
  logic locked;
  logic enable_cond;
  logic bit_tick;
  logic [15:0] status_word;
  assign guard_open = !s_code || !s_head;
  assign locked = s_pin && !guard_open && !s_man;
  assign bit_tick = (st.divcnt == 16'(BIT_PERIOD - 1));
  assign status_word = {8'h00, st.safe, st.jam, st.man_flag, st.diag, st.door2, st.door1, st.lock, 1'b1};

  always_comb
  begin
    next_st = st;
    // locking drive: solenoid voltage with guard fully in and no release
    next_st.drive = s_sol && s_full && !guard_open && !s_man;
    next_st.lock = locked;
    next_st.door1 = !guard_open;
    next_st.door2 = (!guard_open && s_full) || locked;
    // fault is latched until the guard opens while the fault input is clear
    if (s_fault)
      next_st.fault_latch = 1'b1;
    else if (guard_open)
      next_st.fault_latch = 1'b0;
    next_st.diag = s_fault || st.fault_latch;
    // common enable for both outputs
    enable_cond = !guard_open
                  && (locked || !i_mode_active)
                  && (s_chain || !i_chain_used)
                  && !s_fault && !st.fault_latch;
    next_st.safe = enable_cond;
    // manual release flag until command matches actual state
    if (s_man && (s_sol != s_pin || st.lock))
      next_st.man_flag = 1'b1;
    else if (s_sol == s_pin)
      next_st.man_flag = 1'b0;
    // jammed locker: set wins, clears on load or block gone
    if (s_jam && s_load && !s_sol)
      next_st.jam = 1'b1;
    else if (!s_load || !s_jam)
      next_st.jam = 1'b0;
    // communication output: frames when gateway present
    next_st.divcnt = bit_tick ? 16'h0000 : st.divcnt + 16'h0001;
    unique case (st.tx)
      gss_pkg::GSS_TX_IDLE:
      begin
        next_st.comm = st.safe;
        if (s_gw && bit_tick)
        begin
          next_st.shreg = (st.framecnt == 3'(`GSS_ACYC_EVERY - 1)) ? `GSS_ACYC_WORD : status_word;
          next_st.framecnt = (st.framecnt == 3'(`GSS_ACYC_EVERY - 1)) ? 3'h0 : st.framecnt + 3'h1;
          next_st.bitcnt = 5'h00;
          next_st.tx = gss_pkg::GSS_TX_SHIFT;
        end
      end
      gss_pkg::GSS_TX_SHIFT:
      begin
        if (bit_tick)
        begin
          next_st.comm = st.shreg[0];
          next_st.shreg = {1'b0, st.shreg[15:1]};
          next_st.bitcnt = st.bitcnt + 5'h01;
          if (st.bitcnt == 5'(FRAME_BITS - 1) || !s_gw)
            next_st.tx = gss_pkg::GSS_TX_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      st <= '0;
      st.tx <= gss_pkg::GSS_TX_IDLE;
    end
    else
      st <= next_st;
  end

  // outputs straight from registers
  assign o_safe_out_a = st.safe;
  assign o_safe_out_b = st.safe;
  assign o_output_on_flag = st.safe;
  assign o_lock_status = st.lock;
  assign o_door_pos_first = st.door1;
  assign o_door_pos_second = st.door2;
  assign o_diag_flag = st.diag;
  assign o_diag_indicator = st.diag;
  assign o_manual_release_flag = st.man_flag;
  assign o_jammed_locker_flag = st.jam;
  assign o_lock_drive = st.drive;
  assign o_comm_out = st.comm;

  // ****************************************
  // assertions
  // ****************************************
  property p_open_off;
    @(posedge i_mclk) disable iff (i_sys_rst) guard_open |=> !o_safe_out_a && !o_safe_out_b;
  endproperty
  a_open_off: assert property (p_open_off) else $error("outputs on with guard open");

  property p_chain;
    @(posedge i_mclk) disable iff (i_sys_rst) (i_chain_used && !s_chain) |=> !o_safe_out_a;
  endproperty
  a_chain: assert property (p_chain) else $error("output on without chain enable");

  property p_door1;
    @(posedge i_mclk) disable iff (i_sys_rst) (s_code && s_head) |=> o_door_pos_first;
  endproperty
  a_door1: assert property (p_door1) else $error("door one missing");

  property p_fault;
    @(posedge i_mclk) disable iff (i_sys_rst) s_fault |=> (!o_safe_out_a && o_diag_indicator);
  endproperty
  a_fault: assert property (p_fault) else $error("fault not handled");

  property p_active;
    @(posedge i_mclk) disable iff (i_sys_rst) (i_mode_active && !locked) |=> !o_safe_out_b;
  endproperty
  a_active: assert property (p_active) else $error("active mode output unlocked");

  property p_lock;
    @(posedge i_mclk) disable iff (i_sys_rst) 1'b1 |=> (o_lock_status == $past(locked));
  endproperty
  a_lock: assert property (p_lock) else $error("lock status mismatch");

  sequence s_door2_up;
    o_door_pos_second && !$past(o_door_pos_second);
  endsequence
  property p_door_order;
    @(posedge i_mclk) disable iff (i_sys_rst) s_door2_up |-> o_door_pos_first;
  endproperty
  a_door_order: assert property (p_door_order) else $error("door two before door one");

  property p_same;
    @(posedge i_mclk) disable iff (i_sys_rst) (o_safe_out_a == o_safe_out_b) && (o_output_on_flag == o_safe_out_a);
  endproperty
  a_same: assert property (p_same) else $error("outputs differ");

  property p_plain;
    @(posedge i_mclk) disable iff (i_sys_rst) (!s_gw && st.tx == gss_pkg::GSS_TX_IDLE) |=> o_comm_out == $past(st.safe);
  endproperty
  a_plain: assert property (p_plain) else $error("comm output not plain");

  property p_door2;
    @(posedge i_mclk) disable iff (i_sys_rst) ((!guard_open && s_full) || locked) |=> o_door_pos_second;
  endproperty
  a_door2: assert property (p_door2) else $error("door two missing");

  property p_drive;
    @(posedge i_mclk) disable iff (i_sys_rst) (s_sol && s_full && !guard_open && !s_man) |=> o_lock_drive;
  endproperty
  a_drive: assert property (p_drive) else $error("locking not engaged");

  property p_man_clr;
    @(posedge i_mclk) disable iff (i_sys_rst) (s_sol == s_pin && !(s_man && st.lock)) |=> !o_manual_release_flag;
  endproperty
  a_man_clr: assert property (p_man_clr) else $error("release flag not cleared");

  property p_jam_set;
    @(posedge i_mclk) disable iff (i_sys_rst) (s_jam && s_load && !s_sol) |=> o_jammed_locker_flag;
  endproperty
  a_jam_set: assert property (p_jam_set) else $error("jammed flag missing");

  property p_jam_clr;
    @(posedge i_mclk) disable iff (i_sys_rst) (!s_load || !s_jam) |=> !o_jammed_locker_flag;
  endproperty
  a_jam_clr: assert property (p_jam_clr) else $error("jammed flag not cleared");

endmodule
`default_nettype wire

// file: test/gss_ctrl_model.sv
// chain predecessor and controller model reading the block comm output
`timescale 1ns/1ps
`default_nettype none
module gss_ctrl_model (
  // clock
  input wire logic i_mclk,
  // bench commands
  input wire logic i_pred_ok,
  input wire logic i_gw_on,
  // block side
  input wire logic i_comm,
  output logic o_chain_enable,
  output logic o_gateway_present,
  output int o_edges
);
  logic last;
  // quiet lines at time zero
  initial
  begin
    o_chain_enable = 1'b0;
    o_gateway_present = 1'b0;
    o_edges = 0;
    last = 1'b0;
  end
  // enable and gateway follow commands; count comm edges while attached
  always @(posedge i_mclk)
  begin
    o_chain_enable <= i_pred_ok;
    o_gateway_present <= i_gw_on;
    last <= i_comm;
    o_edges <= !i_gw_on ? 0 : ((i_comm !== last) ? o_edges + 1 : o_edges);
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the guard status signal logic
`timescale 1ns/1ps
`default_nettype none
`include "gss_map.svh"
`define CHK(nm, e, s) \
  begin cmp_count++; if ((s) !== 1'(e)) begin error_cnt++; $display("BAD %s exp %0d got %b", nm, e, s); end end
module testbench;
  // clock, reset and pins driven by the bench
  logic i_mclk, i_sys_rst, cv, he, fi, sv, mr, pe, pj, tl, flt, ma, cu, pred, gw;
  // block outputs and partner lines
  wire logic sa, sb, ls, d1, d2, dg, di, mf, of, jf, ld, co, ce, gp;
  int edges, seed = 24418, error_cnt = 0, cmp_count = 0, cyc = 0, fl = 0, mfl = 0, jm = 0, op = 0, lk = 0, sf = 0;
  // expected cyclic word and captured comm samples, one per clock
  logic [15:0] cw;
  logic cq[$];
  // free running clock
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // short bit period keeps frames quick
  gss_core #(.BIT_PERIOD(4)) gss_core_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_code_valid(cv),
    .i_head_entered(he), .i_full_insert(fi), .i_solenoid_v(sv), .i_manual_release(mr), .i_pin_extended(pe),
    .i_pin_jammed(pj), .i_tensile_load(tl), .i_chain_enable(ce), .i_internal_fault(flt), .i_mode_active(ma),
    .i_chain_used(cu), .i_gateway_present(gp), .o_safe_out_a(sa), .o_safe_out_b(sb), .o_lock_status(ls),
    .o_door_pos_first(d1), .o_door_pos_second(d2), .o_diag_flag(dg), .o_diag_indicator(di),
    .o_manual_release_flag(mf), .o_output_on_flag(of), .o_jammed_locker_flag(jf), .o_lock_drive(ld),
    .o_comm_out(co));
  gss_ctrl_model gss_ctrl_model_i (.i_mclk(i_mclk), .i_pred_ok(pred), .i_gw_on(gw), .i_comm(co),
    .o_chain_enable(ce), .o_gateway_present(gp), .o_edges(edges));
  // biased random bit, one in n comes out low
  function automatic logic rb(input int n);
    return ({$random(seed)} % n) != 0;
  endfunction
  // true when the word shows up lsb first, one bit per four samples
  function automatic logic has_word(input logic [15:0] w);
    logic hit;
    logic ok;
    hit = 1'b0;
    for (int o = 0; o + 60 < cq.size(); o++)
    begin
      ok = 1'b1;
      for (int k = 0; k < 16; k++)
        if (cq[o + 4 * k] !== w[k])
          ok = 1'b0;
      hit = hit | ok;
    end
    return hit;
  endfunction
  // report and stop
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one random pin pattern, let it settle, compare with the reference model
  task automatic step(input logic g);
    @(posedge i_mclk);
    {cv, he, fi, pe, sv, ma, cu, pred} <= {rb(5), rb(5), rb(3), rb(3), rb(2), rb(2), rb(2), rb(4)};
    {mr, flt, pj, tl, gw} <= {!rb(5), !rb(9), !rb(2), !rb(2), g};
    repeat (6) @(posedge i_mclk);
    #1;
    op = !(cv && he);
    lk = pe && !op && !mr;
    fl = flt ? 1 : (op ? 0 : fl);
    sf = !op && (lk || !ma) && (pred || !cu) && !flt && !fl;
    mfl = (mr && (sv != pe || lk)) ? 1 : ((sv == pe) ? 0 : mfl);
    jm = (pj && tl && !sv) ? 1 : ((!tl || !pj) ? 0 : jm);
    `CHK("safe_out_a", sf, sa)
    `CHK("safe_out_b", sf, sb)
    `CHK("output_on_flag", sf, of)
    `CHK("lock_status", lk, ls)
    `CHK("door_pos_first", !op, d1)
    `CHK("door_pos_second", (!op && fi) || lk, d2)
    `CHK("diag_flag", flt || fl, dg)
    `CHK("diag_indicator", flt || fl, di)
    `CHK("manual_release_flag", mfl, mf)
    `CHK("jammed_locker_flag", jm, jf)
    `CHK("lock_drive", sv && fi && !op && !mr, ld)
    if (!g) `CHK("comm_plain", sf, co)
  endtask
  // hang guard
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  // main sequence
  initial
  begin
    {cv, he, fi, sv, mr, pe, pj, tl, flt, ma, cu, pred, gw} = '0;
    i_sys_rst = 1'b1;
    repeat (5) @(posedge i_mclk);
    #1;
    `CHK("reset_outs", 0, |{sa, sb, ls, d1, d2, dg, mf, of, jf, ld, co})
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (300) step(1'b0);
    // gateway attached: pins then stay still while frames are captured
    step(1'b1);
    cw = {8'h00, sf != 0, jm != 0, mfl != 0, flt || fl != 0, (!op && fi) || lk != 0, op == 0, lk != 0, 1'b1};
    repeat (500)
    begin
      @(posedge i_mclk);
      #1;
      cq.push_back(co);
    end
    `CHK("comm_frames", 1, edges > 4)
    `CHK("comm_cyclic", 1, has_word(cw))
    `CHK("comm_acyclic", 1, has_word(`GSS_ACYC_WORD))
    // second reset in mid-run with quiet pins
    @(posedge i_mclk);
    {cv, he, fi, sv, mr, pe, pj, tl, flt, ma, cu, pred, gw} <= '0;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    `CHK("reset_again", 0, |{sa, sb, ls, d1, d2, dg, mf, of, jf, ld, co})
    fl = 0;
    mfl = 0;
    jm = 0;
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (40) step(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
